// ===== bcl_pkg.sv
// constants, field layout, decode tables and types of the closed-loop
// configuration bank; assumes a single pclk domain and an apb master
package bcl_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_COMM_PWM   = 10'h086;
	localparam logic [9:0] IDX_SPEED_STOP = 10'h088;
	localparam logic [9:0] IDX_DEGAUSS    = 10'h08a;
	localparam logic [9:0] IDX_STATUS     = 10'h0a0;

	// reset values
	localparam logic [31:0] RST_COMM_PWM   = 32'h0000_0000;
	localparam logic [31:0] RST_SPEED_STOP = 32'h0000_0000;
	localparam logic [31:0] RST_DEGAUSS    = 32'h1400_0000;

	// writable bits; reserved bits stay zero
	localparam logic [31:0] WMASK_COMM_PWM   = 32'hffff_fffe;
	localparam logic [31:0] WMASK_SPEED_STOP = 32'hffff_fff8;
	localparam logic [31:0] WMASK_DEGAUSS    = 32'hffff_ffff;

	// commutation and pwm register fields (lsb positions)
	localparam int COMM_STYLE_LSB = 29, ACCEL_LSB = 24, DECEL_SEL_BIT = 23;
	localparam int DECEL_LSB = 18, FREQ_LSB = 13, MOD_LSB = 11;
	localparam int COMPL_BIT = 10, ADV_SIGN_BIT = 9, ADV_ANGLE_LSB = 1;

	// speed pulse and stop register fields
	localparam int SP_MODE_LSB = 29, SP_DIV_LSB = 25, SP_STOP_BIT = 24;
	localparam int SP_EMF_LSB = 21, STOP_LSB = 18, BRAKE_TIME_LSB = 14;
	localparam int STOP_DUTY_LSB = 11, PIN_DUTY_LSB = 8, SURGE_BIT = 7;
	localparam int ILIM_LSB = 3;

	// degauss and integration register fields
	localparam int DGS_CNT_LSB = 29, DGS_UP_LSB = 27, DGS_LO_LSB = 25;
	localparam int INT_SLO_LSB = 23, INT_SHI_LSB = 21, INT_DLO_LSB = 19;
	localparam int INT_DHI_LSB = 17, FALL_EMF_LSB = 11, RISE_EMF_LSB = 5;
	localparam int METHOD_BIT = 4, DGS_WIN_LSB = 1, DGS_EN_BIT = 0;

	// decoded settings handed to the commutation and stop logic
	typedef struct packed {
		logic              variable_comm;     // 120..150 degree commutation
		logic [4:0]        loop_accel_rate;   // rate table code
		logic [4:0]        loop_decel_rate;   // effective rate table code
		logic [6:0]        pwm_khz;           // switching frequency
		logic [1:0]        modulation_side;
		logic              complementary;
		logic signed [8:0] advance_steps;     // 0.12 degree steps
		logic [1:0]        speed_pulse_mode;
		logic [3:0]        speed_pulse_div;   // 1..15
		logic              speed_pulse_while_driven;
		logic [4:0]        speed_pulse_emf_mv;
		logic [2:0]        stop_method;
		logic [13:0]       stop_brake_ms;
		logic [9:0]        stop_duty_pm;      // per mille, 0 = immediate
		logic [9:0]        brake_pin_duty_pm; // per mille, 0 = immediate
		logic              surge_guard_enable;
		logic [4:0]        current_limit_dv;  // sense volts in 0.1 v
		logic [2:0]        degauss_samples;
		logic [7:0]        degauss_upper_drop_mv;
		logic [6:0]        degauss_lower_mv;
		logic [3:0]        integ_sample_low;
		logic [3:0]        integ_sample_high;
		logic [4:0]        integ_duty_low_pct;
		logic [4:0]        integ_duty_high_pct;
		logic [11:0]       falling_emf_limit;
		logic [11:0]       rising_emf_limit;
		logic              integration_method;
		logic [9:0]        degauss_window_tenths;
		logic              adaptive_degauss_enable;
	} bcl_settings_type;

	// stop and brake-pin duty thresholds share one table
	function automatic logic [9:0] bcl_duty_pm(input logic [2:0] code);
		unique case (code)
			3'h0: bcl_duty_pm = 10'd0;
			3'h1: bcl_duty_pm = 10'd500;
			3'h2: bcl_duty_pm = 10'd250;
			3'h3: bcl_duty_pm = 10'd150;
			3'h4: bcl_duty_pm = 10'd100;
			3'h5: bcl_duty_pm = 10'd75;
			3'h6: bcl_duty_pm = 10'd50;
			3'h7: bcl_duty_pm = 10'd25;
		endcase
	endfunction

	// integration thresholds: steps of 25, 50, 100, then 200
	function automatic logic [11:0] bcl_emf_limit(input logic [5:0] code);
		logic [11:0] c;
		c = {6'h00, code};
		if (code < 6'd32)
			bcl_emf_limit = 12'(c * 12'd25);
		else if (code < 6'd48)
			bcl_emf_limit = 12'(12'd800 + (c - 12'd32) * 12'd50);
		else if (code < 6'd57)
			bcl_emf_limit = 12'(12'd1600 + (c - 12'd48) * 12'd100);
		else
			bcl_emf_limit = 12'(12'd2600 + (c - 12'd57) * 12'd200);
	endfunction

endpackage

// ===== bcl_config_bank.sv
// closed-loop configuration register bank with decoded settings outputs
// assumes an apb master on pclk; the motor loop reads the settings struct
// What this block does
// - commutation code picks 120 or variable 120-150
// - acceleration code selects ramp rate table entry
// - deceleration follows acceleration when selector set
// - frequency code: 1 khz then 5 khz steps
// - modulation code picks high, low or mixed
// - style bit picks single-ended or complementary switching
// - lead angle is steps times 0.12, signed
// - speed pulse mode picks open/closed loop output
// - speed pulse divider: code zero means three
// - stop bit: until emf threshold or while driven
// - emf threshold code gives 1 to 30 mv
// - stop method code picks coast, brake or spin-down
// - braking duration from 1 to 15000 ms
// - stop duty threshold immediate or 50 to 2.5
// - brake pin duty threshold uses same table
// - current limit 0.1 v per code, zero unused
// - degauss check needs two to five samples
// - degauss upper and lower bounds reset to two
// - sample counts switch integration and zero-cross
// - duty thresholds switch integration and zero-cross
// - falling and rising integration limits nonlinear table
// - method bit picks zero-cross or integration
// - degauss window table and adaptive degauss enable
//
// The APB slave port was chosen for this implementation.
module bcl_config_bank
	import bcl_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	input  wire logic [3:0]       pstrb,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	output bcl_settings_type      settings
);

	logic [31:0]      comm_pwm_q;
	logic [31:0]      speed_stop_q;
	logic [31:0]      degauss_q;
	logic [31:0]      prdata_q;
	logic [31:0]      status;
	logic [9:0]       idx;
	logic             mapped;
	logic             setup;
	logic             access;
	logic             wr_comm;
	logic             wr_speed;
	logic             wr_degauss;
	bcl_settings_type settings_d;
	bcl_settings_type settings_q;

	// merge write data through byte strobes and the writable mask
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  strb,
		input logic [31:0] wmask
	);
		logic [31:0] lanes;
		lanes = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			lanes[i*8 +: 8] = {8{strb[i]}};
		end
		merge = (old & ~(lanes & wmask)) | (wdata & lanes & wmask);
	endfunction

	// address decode; no wait states, so pready is always high
	assign idx        = paddr[11:2];
	assign mapped     = (idx == IDX_COMM_PWM) || (idx == IDX_SPEED_STOP) ||
	                    (idx == IDX_DEGAUSS) || (idx == IDX_STATUS);
	assign setup      = psel & ~penable;
	assign access     = psel & penable;
	assign pready     = 1'b1;
	assign pslverr    = access & ~mapped;
	assign wr_comm    = access & pwrite & (idx == IDX_COMM_PWM);
	assign wr_speed   = access & pwrite & (idx == IDX_SPEED_STOP);
	assign wr_degauss = access & pwrite & (idx == IDX_DEGAUSS);

	// commutation and pwm register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comm_pwm_q <= RST_COMM_PWM;
		else if (wr_comm)
			comm_pwm_q <= merge(comm_pwm_q, pwdata, pstrb, WMASK_COMM_PWM);
	end

	// speed pulse and stop register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			speed_stop_q <= RST_SPEED_STOP;
		else if (wr_speed)
			speed_stop_q <= merge(speed_stop_q, pwdata, pstrb,
			                      WMASK_SPEED_STOP);
	end

	// degauss and integration register; bounds reset to code two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			degauss_q <= RST_DEGAUSS;
		else if (wr_degauss)
			degauss_q <= merge(degauss_q, pwdata, pstrb, WMASK_DEGAUSS);
	end

	// status flags unused codes currently programmed
	always_comb begin
		status    = 32'h0000_0000;
		status[0] = comm_pwm_q[COMM_STYLE_LSB+1];
		status[1] = &comm_pwm_q[MOD_LSB +: 2];
		status[2] = &speed_stop_q[SP_MODE_LSB +: 2];
		status[3] = &speed_stop_q[SP_EMF_LSB+1 +: 2];
		status[4] = speed_stop_q[STOP_LSB +: 3] > 3'h4;
		status[5] = speed_stop_q[ILIM_LSB +: 4] == 4'h0;
	end

	// read data is captured in the setup phase, valid in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (setup && !pwrite) begin
			unique case (idx)
				IDX_COMM_PWM:   prdata_q <= comm_pwm_q;
				IDX_SPEED_STOP: prdata_q <= speed_stop_q;
				IDX_DEGAUSS:    prdata_q <= degauss_q;
				IDX_STATUS:     prdata_q <= status;
				default:        prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata = prdata_q;

	// braking duration table
	function automatic logic [13:0] brake_ms(input logic [3:0] code);
		unique case (code)
			4'h0: brake_ms = 14'd1;
			4'h1: brake_ms = 14'd2;
			4'h2: brake_ms = 14'd5;
			4'h3: brake_ms = 14'd10;
			4'h4: brake_ms = 14'd15;
			4'h5: brake_ms = 14'd25;
			4'h6: brake_ms = 14'd50;
			4'h7: brake_ms = 14'd75;
			4'h8: brake_ms = 14'd100;
			4'h9: brake_ms = 14'd250;
			4'ha: brake_ms = 14'd500;
			4'hb: brake_ms = 14'd1000;
			4'hc: brake_ms = 14'd2500;
			4'hd: brake_ms = 14'd5000;
			4'he: brake_ms = 14'd10000;
			4'hf: brake_ms = 14'd15000;
		endcase
	endfunction

	// degauss window in tenths of a degree
	function automatic logic [9:0] window_tenths(input logic [2:0] code);
		unique case (code)
			3'h0: window_tenths = 10'd225;
			3'h1: window_tenths = 10'd100;
			3'h2: window_tenths = 10'd150;
			3'h3: window_tenths = 10'd180;
			3'h4: window_tenths = 10'd300;
			3'h5: window_tenths = 10'd375;
			3'h6: window_tenths = 10'd450;
			3'h7: window_tenths = 10'd600;
		endcase
	endfunction

	// emf threshold that ends speed pulses
	function automatic logic [4:0] emf_mv(input logic [2:0] code);
		unique case (code)
			3'h0: emf_mv = 5'd1;
			3'h1: emf_mv = 5'd2;
			3'h2: emf_mv = 5'd5;
			3'h3: emf_mv = 5'd10;
			3'h4: emf_mv = 5'd20;
			3'h5: emf_mv = 5'd30;
			default: emf_mv = 5'd30; // unused codes hold the widest band
		endcase
	endfunction

	// small tables of four entries
	function automatic logic [3:0] pick4(input logic [1:0] code,
	                                     input logic [15:0] tbl);
		pick4 = tbl[code*4 +: 4];
	endfunction

	// decode of the commutation and pwm register
	always_comb begin
		logic [4:0] f;
		logic [8:0] a;
		f = comm_pwm_q[FREQ_LSB +: 5];
		a = {1'b0, comm_pwm_q[ADV_ANGLE_LSB +: 8]};
		settings_d = '0;
		settings_d.variable_comm   = comm_pwm_q[COMM_STYLE_LSB +: 2] == 2'h1;
		settings_d.loop_accel_rate = comm_pwm_q[ACCEL_LSB +: 5];
		settings_d.loop_decel_rate = comm_pwm_q[DECEL_SEL_BIT] ?
		                             comm_pwm_q[ACCEL_LSB +: 5] :
		                             comm_pwm_q[DECEL_LSB +: 5];
		if (f < 5'd16)
			settings_d.pwm_khz = 7'(7'd5 + {2'b00, f});
		else
			settings_d.pwm_khz = 7'(7'd20 + ({2'b00, f} - 7'd15) * 7'd5);
		settings_d.modulation_side = comm_pwm_q[MOD_LSB +: 2];
		settings_d.complementary   = comm_pwm_q[COMPL_BIT];
		settings_d.advance_steps   = comm_pwm_q[ADV_SIGN_BIT] ?
		                             $signed(a) : -$signed(a);

		// speed pulse output and stop behaviour
		settings_d.speed_pulse_mode = speed_stop_q[SP_MODE_LSB +: 2];
		settings_d.speed_pulse_div  = (speed_stop_q[SP_DIV_LSB +: 4] == 4'h0) ?
		                              4'h3 : speed_stop_q[SP_DIV_LSB +: 4];
		settings_d.speed_pulse_while_driven = speed_stop_q[SP_STOP_BIT];
		settings_d.speed_pulse_emf_mv = emf_mv(speed_stop_q[SP_EMF_LSB +: 3]);
		settings_d.stop_method   = speed_stop_q[STOP_LSB +: 3];
		settings_d.stop_brake_ms = brake_ms(speed_stop_q[BRAKE_TIME_LSB +: 4]);
		settings_d.stop_duty_pm  = bcl_duty_pm(speed_stop_q[STOP_DUTY_LSB +: 3]);
		settings_d.brake_pin_duty_pm =
			bcl_duty_pm(speed_stop_q[PIN_DUTY_LSB +: 3]);
		settings_d.surge_guard_enable = speed_stop_q[SURGE_BIT];
		settings_d.current_limit_dv = {1'b0, speed_stop_q[ILIM_LSB +: 4]};

		// degauss and commutation method switching
		settings_d.degauss_samples =
			3'({1'b0, degauss_q[DGS_CNT_LSB +: 2]} + 3'd2);
		settings_d.degauss_upper_drop_mv =
			8'(8'd90 + {6'h00, degauss_q[DGS_UP_LSB +: 2]} * 8'd30);
		settings_d.degauss_lower_mv =
			7'(7'd30 + {5'h00, degauss_q[DGS_LO_LSB +: 2]} * 7'd30);
		settings_d.integ_sample_low =
			pick4(degauss_q[INT_SLO_LSB +: 2], 16'h8643);
		settings_d.integ_sample_high =
			pick4(degauss_q[INT_SHI_LSB +: 2], 16'ha864);
		settings_d.integ_duty_low_pct = 5'(8'h0c + 8'(degauss_q[INT_DLO_LSB +: 2])
			* 8'h03 - ((degauss_q[INT_DLO_LSB +: 2] == 2'h3) ? 8'h01 : 8'h00));
		settings_d.integ_duty_high_pct = 5'(8'h0c + 8'(degauss_q[INT_DHI_LSB +: 2])
			* 8'h03 - ((degauss_q[INT_DHI_LSB +: 2] == 2'h3) ? 8'h01 : 8'h00));
		settings_d.falling_emf_limit =
			bcl_emf_limit(degauss_q[FALL_EMF_LSB +: 6]);
		settings_d.rising_emf_limit =
			bcl_emf_limit(degauss_q[RISE_EMF_LSB +: 6]);
		settings_d.integration_method = degauss_q[METHOD_BIT];
		settings_d.degauss_window_tenths =
			window_tenths(degauss_q[DGS_WIN_LSB +: 3]);
		settings_d.adaptive_degauss_enable = degauss_q[DGS_EN_BIT];
	end

	// settings reach the loop one cycle after the register changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			settings_q <= '0;
		else
			settings_q <= settings_d;
	end

	assign settings = settings_q;

	// a full-strobe write to a register followed by its read-back
	sequence wr_deg_s;
		access && pwrite && idx == IDX_DEGAUSS && pstrb == 4'hf;
	endsequence

	sequence rd_deg_s;
		setup && !pwrite && idx == IDX_DEGAUSS;
	endsequence

	property deg_readback_p;
		@(posedge pclk) disable iff (!presetn)
		wr_deg_s ##1 rd_deg_s |=> prdata == $past(pwdata, 2);
	endproperty

	deg_readback_a: assert property (deg_readback_p)
		else $error("degauss register did not read back the written word");

	reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_comm && pstrb == 4'hf |=> comm_pwm_q[0] == 1'b0 &&
		comm_pwm_q[31:1] == $past(pwdata[31:1]))
		else $error("reserved bit stored or write lost");

	decel_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		comm_pwm_q[DECEL_SEL_BIT] |=>
		settings.loop_decel_rate == $past(comm_pwm_q[ACCEL_LSB +: 5]))
		else $error("deceleration does not follow acceleration");

	div_three_a: assert property (@(posedge pclk) disable iff (!presetn)
		speed_stop_q[SP_DIV_LSB +: 4] == 4'h0 |=> settings.speed_pulse_div == 4'h3)
		else $error("divider code zero must divide by three");

	pwm_top_a: assert property (@(posedge pclk) disable iff (!presetn)
		comm_pwm_q[FREQ_LSB +: 5] == 5'h1f |=> settings.pwm_khz == 7'd100)
		else $error("top frequency code is not 100 khz");

	emf_top_a: assert property (@(posedge pclk) disable iff (!presetn)
		degauss_q[FALL_EMF_LSB +: 6] == 6'h3f |=>
		settings.falling_emf_limit == 12'd3800)
		else $error("top falling limit is not 3800");

	lead_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
		!comm_pwm_q[ADV_SIGN_BIT] && comm_pwm_q[ADV_ANGLE_LSB +: 8] != 8'h00 |=>
		settings.advance_steps < 0)
		else $error("negative lead angle sign not applied");

	stop_now_a: assert property (@(posedge pclk) disable iff (!presetn)
		speed_stop_q[STOP_DUTY_LSB +: 3] == 3'h0 |=> settings.stop_duty_pm == 10'd0)
		else $error("immediate stop threshold not zero");

	dgs_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(degauss_q[DGS_CNT_LSB +: 2]) |=> settings.degauss_samples ==
		3'({1'b0, $past(degauss_q[DGS_CNT_LSB +: 2])} + 3'd2))
		else $error("degauss sample count wrong");

	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !mapped ##1 access |-> pslverr)
		else $error("unmapped access not refused");

	// field decodes seen on settings one cycle after the register
	comm_variable_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		comm_pwm_q[COMM_STYLE_LSB +: 2] == 2'h1 |=> settings.variable_comm)
		else $error("variable commutation not selected");
	comm_fixed_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		comm_pwm_q[COMM_STYLE_LSB +: 2] != 2'h1 |=> !settings.variable_comm)
		else $error("fixed commutation not selected");
	decel_own_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!comm_pwm_q[DECEL_SEL_BIT] |=>
		settings.loop_decel_rate == $past(comm_pwm_q[DECEL_LSB +: 5]))
		else $error("deceleration does not use its own field");
	pwm_low_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		comm_pwm_q[FREQ_LSB +: 5] == 5'h00 |=> settings.pwm_khz == 7'd5)
		else $error("lowest frequency code is not 5 khz");
	lead_pos_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		comm_pwm_q[ADV_SIGN_BIT] |=> settings.advance_steps >= 0)
		else $error("positive lead angle sign not applied");
	emf_unused_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		speed_stop_q[SP_EMF_LSB +: 3] > 3'h5 |=>
		settings.speed_pulse_emf_mv == 5'd30)
		else $error("unused emf code not held at widest band");
	brake_top_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		speed_stop_q[BRAKE_TIME_LSB +: 4] == 4'hf |=>
		settings.stop_brake_ms == 14'd15000)
		else $error("top braking duration is not 15000 ms");
	pin_now_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		speed_stop_q[PIN_DUTY_LSB +: 3] == 3'h0 |=>
		settings.brake_pin_duty_pm == 10'd0)
		else $error("immediate brake pin threshold not zero");
	ilim_copy_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		speed_stop_q[ILIM_LSB +: 4] != 4'h0 |=> settings.current_limit_dv ==
		{1'b0, $past(speed_stop_q[ILIM_LSB +: 4])})
		else $error("current limit code not passed on");
	method_int_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		degauss_q[METHOD_BIT] |=> settings.integration_method)
		else $error("integration method not selected");
	window_first_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		degauss_q[DGS_WIN_LSB +: 3] == 3'h0 |=>
		settings.degauss_window_tenths == 10'd225)
		else $error("first degauss window is not 22.5 degrees");
	unmapped_data_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup && !mapped && !pwrite ##1 access |-> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");

endmodule

// ===== bcl_motor_model.sv
// motor-side stand-in that latches what the drive stage would apply
// assumes the settings struct arrives from the bank on pclk
module bcl_motor_model
	import bcl_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire bcl_settings_type settings,
	output logic       [6:0]      applied_khz,
	output logic       [2:0]      applied_stop
);
	// one-cycle latch, as a drive stage picks up a new setting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			applied_khz <= 7'h00;
			applied_stop <= 3'h0;
		end else begin
			applied_khz <= settings.pwm_khz;
			applied_stop <= settings.stop_method;
		end
	end
endmodule

// ===== bcl_config_bank_tb_top.sv
// self-checking bench for the closed-loop configuration bank
// assumes bcl_pkg, the bank and the motor-side model compiled first
module bcl_config_bank_tb_top
	import bcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] A_COMM = {IDX_COMM_PWM, 2'b00};
	localparam logic [11:0] A_SPD  = {IDX_SPEED_STOP, 2'b00};
	localparam logic [11:0] A_DGS  = {IDX_DEGAUSS, 2'b00};
	localparam logic [11:0] A_STAT = {IDX_STATUS, 2'b00};
	localparam logic [11:0] A_NONE = 12'h3fc;
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [11:0]      paddr = 12'h000;
	logic [31:0]      pwdata = 32'h0000_0000;
	logic [3:0]       pstrb = 4'h0;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	bcl_settings_type settings;
	logic [6:0]       applied_khz;
	logic [2:0]       applied_stop;
	logic [31:0]      rd;
	logic             err;
	bit               b2b = 1'b0;
	int               bad_count = 0;
	int               tests_run = 0;
	int               fc[4] = '{0, 15, 16, 31};
	int               fk[4] = '{5, 20, 25, 100};

	bcl_config_bank bcl_config_bank_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.settings(settings)
	);
	bcl_motor_model bcl_motor_model_inst (
		.pclk(pclk), .presetn(presetn), .settings(settings),
		.applied_khz(applied_khz), .applied_stop(applied_stop)
	);

	// 125 mhz clock
	always #4 pclk = ~pclk;

	// counts, verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// compare one value and log a mismatch at once
	task automatic chk(input logic [31:0] got, exp, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	// one apb transfer; waits for pready under a bound; nxt keeps psel up
	// so that the next setup follows the access at once
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, input logic [3:0] st, input bit nxt = 1'b0);
		int n;
		n = 0;
		if (!b2b)
			@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (!nxt) begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
		b2b = nxt;
		if (pready !== 1'b1) begin
			bad_count++;
			results();
		end
	endtask

	// write a word, then let settings and the model catch up
	task automatic wr_set(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
		repeat (3) @(posedge pclk);
	endtask

	// read a word and compare it
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		chk(rd, e, "read back");
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd_chk(A_COMM, RST_COMM_PWM);
		rd_chk(A_SPD, RST_SPEED_STOP);
		rd_chk(A_DGS, 32'h1400_0000);
		chk(32'(settings.degauss_upper_drop_mv), 150, "upper");
		chk(32'(settings.degauss_lower_mv), 90, "lower");
		chk(32'(settings.degauss_samples), 2, "samples");
		chk(32'(settings.speed_pulse_div), 3, "div");
		chk(32'(settings.integ_sample_low), 3, "slo");
		chk(32'(settings.integ_duty_high_pct), 12, "dhi");
		chk(32'(settings.degauss_window_tenths), 225, "win");
		$display("test reset values done");
		wr_set(A_COMM, 32'hbf8e_160b);
		rd_chk(A_COMM, 32'hbf8e_160a);
		chk(32'(settings.variable_comm), 1, "comm");
		chk(32'(settings.loop_accel_rate), 31, "accel");
		chk(32'(settings.loop_decel_rate), 31, "decel sel");
		chk(32'(settings.modulation_side), 2, "mod");
		chk(32'(settings.complementary), 1, "compl");
		chk(32'(settings.advance_steps), 32'h5, "adv pos");
		chk(32'(applied_khz), 25, "model khz");
		wr_set(A_COMM, 32'h9f0e_140a);
		chk(32'(settings.variable_comm), 0, "comm 0");
		chk(32'(settings.loop_decel_rate), 3, "decel");
		chk(32'(settings.advance_steps), 32'hffff_fffb, "adv neg");
		// frequency ends of both step sizes, modulation codes 0 to 2
		for (int i = 0; i < 4; i++) begin
			wr_set(A_COMM, (fc[i] << 13) | ((i % 3) << 11) |
			       (i[0] << 10));
			chk(32'(settings.pwm_khz), fk[i], "khz");
			chk(32'(settings.modulation_side), i % 3, "mod");
			chk(32'(settings.complementary), i % 2, "style");
		end
		$display("test commutation register done");
		wr_set(A_SPD, 32'h2173_f9ff);
		rd_chk(A_SPD, 32'h2173_f9f8);
		chk(32'(settings.speed_pulse_mode), 1, "sp mode");
		chk(32'(settings.speed_pulse_div), 3, "sp div");
		chk(32'(settings.speed_pulse_while_driven), 1, "sp stop");
		chk(32'(settings.speed_pulse_emf_mv), 10, "emf");
		chk(32'(applied_stop), 4, "stop");
		chk(32'(settings.stop_brake_ms), 15000, "brake");
		chk(32'(settings.stop_duty_pm), 25, "stop duty");
		chk(32'(settings.brake_pin_duty_pm), 500, "pin duty");
		chk(32'(settings.current_limit_dv), 15, "ilim");
		chk(32'(settings.surge_guard_enable), 1, "surge");
		wr_set(A_SPD, 32'h4ea0_0000);
		chk(32'(settings.speed_pulse_mode), 2, "sp mode");
		chk(32'(settings.speed_pulse_div), 7, "sp div");
		chk(32'(settings.speed_pulse_while_driven), 0, "sp stop");
		chk(32'(settings.speed_pulse_emf_mv), 30, "emf");
		chk(32'(settings.stop_brake_ms), 1, "brake");
		chk(32'(settings.stop_duty_pm), 0, "stop duty");
		apb(1'b1, A_SPD, 32'hffff_ffff, 4'h1);
		rd_chk(A_SPD, 32'h4ea0_00f8);
		$display("test speed and stop register done");
		apb(1'b1, A_DGS, 32'h67ef_fc11, 4'hf, 1'b1);
		rd_chk(A_DGS, 32'h67ef_fc11);
		chk(32'(settings.degauss_samples), 5, "samples");
		chk(32'(settings.degauss_upper_drop_mv), 90, "upper");
		chk(32'(settings.degauss_lower_mv), 120, "lower");
		chk(32'(settings.integ_sample_low), 8, "slo");
		chk(32'(settings.integ_sample_high), 10, "shi");
		chk(32'(settings.integ_duty_low_pct), 15, "dlo");
		chk(32'(settings.integ_duty_high_pct), 20, "dhi");
		chk(32'(settings.falling_emf_limit), 3800, "fall");
		chk(32'(settings.rising_emf_limit), 800, "rise");
		chk(32'(settings.integration_method), 1, "method");
		chk(32'(settings.adaptive_degauss_enable), 1, "dgs en");
		wr_set(A_DGS, 32'h0000_072e);
		chk(32'(settings.rising_emf_limit), 2600, "rise");
		chk(32'(settings.integration_method), 0, "method");
		chk(32'(settings.degauss_window_tenths), 600, "win");
		$display("test degauss register done");
		// unused codes raise the status flags; status ignores writes
		wr_set(A_COMM, 32'h4000_1800);
		chk(32'(settings.variable_comm), 0, "comm 2");
		wr_set(A_SPD, 32'h60d4_0000);
		chk(32'(settings.speed_pulse_emf_mv), 30, "emf 6");
		apb(1'b1, A_STAT, 32'hffff_ffff, 4'hf);
		chk(32'(err), 0, "status write error");
		rd_chk(A_STAT, 32'h0000_003f);
		$display("test status register done");
		apb(1'b1, A_NONE, 32'hffff_ffff, 4'hf);
		chk(32'(err), 1, "unmapped write error");
		apb(1'b0, A_NONE, 32'h0000_0000, 4'h0);
		chk(32'(err), 1, "unmapped read error");
		chk(rd, 32'h0000_0000, "unmapped data");
		rd_chk(A_DGS, 32'h0000_072e);
		$display("test unmapped address done");
		results();
	end
endmodule
